// file: verification/acc_core_model.sv
// behavioural model of the analog comparator core and its input pins
`timescale 1ns/1ns
module acc_core_model (
   input wire logic power_on,
   input wire logic bandgap_select,
   input wire logic [7:0] noninv_pin_mv,
   input wire logic [7:0] inv_pin_mv,
   input wire logic [7:0] bandgap_mv,
   output logic core_out
);
   logic [7:0] noninv_sel;
   // ==========================================================
   // reference mux and compare; an unpowered core sits low
   assign noninv_sel = bandgap_select ? bandgap_mv : noninv_pin_mv;
   assign core_out = power_on && (noninv_sel > inv_pin_mv);
endmodule

// file: verification/acc_top_sva.sv
// assertion checker for the comparator control block
`timescale 1ns/1ns
module acc_top_sva (
   input wire logic aclk,
   input wire logic aresetn,
   input wire logic s_axi_awvalid,
   input wire logic s_axi_awready,
   input wire logic s_axi_wvalid,
   input wire logic s_axi_wready,
   input wire logic s_axi_bvalid,
   input wire logic s_axi_bready,
   input wire logic s_axi_arvalid,
   input wire logic s_axi_arready,
   input wire logic s_axi_rvalid,
   input wire logic s_axi_rready,
   input wire logic deep_stop,
   input wire logic analog_power_on,
   input wire logic comparator_output_pin_oe_n,
   input wire logic irq
);
   default clocking @(posedge aclk); endclocking
   default disable iff (!aresetn);
   // ==========================================================
   // power, pin and interrupt
   property p_stop_off;
      deep_stop |=> !analog_power_on && comparator_output_pin_oe_n;
   endproperty
   a_stop_off: assert property (p_stop_off) else $error("core stays on in deep stop");
   property p_stop_irq;
      deep_stop |=> !irq;
   endproperty
   a_stop_irq: assert property (p_stop_irq) else $error("irq survives deep stop");
   property p_oe_pwr;
      !comparator_output_pin_oe_n |-> analog_power_on;
   endproperty
   a_oe_pwr: assert property (p_oe_pwr) else $error("pin driven while off");
   // ==========================================================
   // register bus, then covers of deep stop, interrupt and pin
   property p_wr_lat;
      s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready |-> ##[1:2] s_axi_bvalid;
   endproperty
   a_wr_lat: assert property (p_wr_lat) else $error("write response late");
   property p_b_one;
      s_axi_bvalid && s_axi_bready |=> !s_axi_bvalid;
   endproperty
   a_b_one: assert property (p_b_one) else $error("write response repeated");
   property p_aw_block;
      s_axi_bvalid |-> !s_axi_awready && !s_axi_wready;
   endproperty
   a_aw_block: assert property (p_aw_block) else $error("write taken early");
   property p_rd_lat;
      s_axi_arvalid && s_axi_arready |=> s_axi_rvalid;
   endproperty
   a_rd_lat: assert property (p_rd_lat) else $error("read data late");
   property p_r_one;
      s_axi_rvalid && s_axi_rready |=> !s_axi_rvalid;
   endproperty
   a_r_one: assert property (p_r_one) else $error("read data repeated");
   property p_ar_block;
      s_axi_rvalid |-> !s_axi_arready;
   endproperty
   a_ar_block: assert property (p_ar_block) else $error("read taken early");
   c_stop: cover property (deep_stop);
   c_irq: cover property (irq);
   c_pin: cover property (!comparator_output_pin_oe_n);
endmodule
bind acc_top acc_top_sva u_acc_top_sva (.*);

// file: verification/test_acc_top.sv
// self-checking testbench for the comparator control block
`timescale 1ns/1ns
module test_acc_top;
   import acc_pkg::*;
   logic aclk, aresetn, awvalid, wvalid, arvalid, deep_stop;
   logic [3:0] awaddr, araddr;
   logic [31:0] wdata, rdata, d;
   logic awready, wready, bvalid, arready, rvalid;
   logic core_out, power_on, bgs, pin, pin_oe_n, irq;
   logic [1:0] bresp, rresp, r;
   logic [7:0] vpin, vbg;
   int bad_count, cmp_count;
   // modes that flag a falling / rising edge
   localparam logic [3:0] FALL_HIT = 4'hd;
   localparam logic [3:0] RISE_HIT = 4'ha;
   acc_top u_acc_top (.aclk(aclk), .aresetn(aresetn),
      .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
      .s_axi_wdata(wdata), .s_axi_wstrb(4'hf), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
      .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(1'b1),
      .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
      .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(1'b1),
      .deep_stop(deep_stop), .comparator_core_out(core_out), .analog_power_on(power_on),
      .bandgap_select(bgs), .comparator_output_pin(pin),
      .comparator_output_pin_oe_n(pin_oe_n), .irq(irq));
   acc_core_model u_acc_core_model (.power_on(power_on), .bandgap_select(bgs),
      .noninv_pin_mv(vpin), .inv_pin_mv(8'h64), .bandgap_mv(vbg), .core_out(core_out));
   initial begin
      aclk = 1'b0;
      forever #5 aclk = ~aclk;
   end
   task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
      cmp_count++;
      if (got !== exp) begin
         bad_count++;
         $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask
   // ready/response lines are sampled before the edge's own updates land
   task automatic wr(input logic [3:0] a, input logic [31:0] v);
      int n;
      n = 0;
      awaddr <= a;
      wdata <= v;
      awvalid <= 1'b1;
      wvalid <= 1'b1;
      r = 2'h3;
      while (r === 2'h3 && n < 100) begin
         @(posedge aclk);
         n++;
         if (awready) awvalid <= 1'b0;
         if (wready) wvalid <= 1'b0;
         if (bvalid) r = bresp;
      end
      if (n >= 100) bad_count++;
   endtask
   task automatic rd(input logic [3:0] a);
      int n;
      n = 0;
      araddr <= a;
      arvalid <= 1'b1;
      r = 2'h3;
      while (r === 2'h3 && n < 100) begin
         @(posedge aclk);
         n++;
         if (arready) arvalid <= 1'b0;
         if (rvalid) begin
            d = rdata;
            r = rresp;
         end
      end
      if (n >= 100) bad_count++;
   endtask
   task automatic rdc(input logic [3:0] a, input logic [31:0] exp);
      rd(a);
      cmp(d, exp);
   endtask
   task automatic give_verdict();
      $display("comparisons=%0d mismatches=%0d", cmp_count, bad_count);
      if (bad_count == 0 && cmp_count > 0) begin
         $display("Test passed");
      end else begin
         $display("Test failed");
      end
      $finish;
   endtask
   initial begin
      #100000;
      bad_count++;
      give_verdict();
   end
   initial begin
      {aresetn, awvalid, wvalid, arvalid, deep_stop} = 5'h0;
      {awaddr, araddr, wdata} = 40'h0;
      vpin = 8'h32;
      vbg = 8'h00;
      bad_count = 0;
      cmp_count = 0;
      repeat (6) @(posedge aclk);
      aresetn <= 1'b1;
      repeat (2) @(posedge aclk);
      rdc(ACC_OFS_CTRL, 32'h0);
      rdc(4'hc, 32'h0);
      cmp(r, ACC_RESP_SLVERR);
      wr(4'hc, 32'h1);
      cmp(r, ACC_RESP_SLVERR);
      $display("test map done");
      wr(ACC_OFS_CTRL, 32'h95);
      repeat (10) @(posedge aclk);
      rdc(ACC_OFS_CTRL, 32'h95);
      vpin <= 8'h96;
      repeat (10) @(posedge aclk);
      rdc(ACC_OFS_CTRL, 32'hbd);
      cmp(irq, 1'b1);
      cmp({pin, pin_oe_n}, 2'b10);
      wr(ACC_OFS_CTRL, 32'h95);
      rdc(ACC_OFS_CTRL, 32'hbd);
      wr(ACC_OFS_CTRL, 32'hb1);
      repeat (2) @(posedge aclk);
      rdc(ACC_OFS_CTRL, 32'h99);
      cmp({irq, pin_oe_n}, 2'b01);
      $display("test flag done");
      for (int m = 0; m < 4; m++) begin
         wr(ACC_OFS_CTRL, 32'ha0 | 32'(m));
         vpin <= 8'h32;
         repeat (10) @(posedge aclk);
         rdc(ACC_OFS_CTRL, 32'h80 | 32'(m) | (FALL_HIT[m] ? 32'h20 : 32'h0));
         wr(ACC_OFS_CTRL, 32'ha0 | 32'(m));
         vpin <= 8'h96;
         repeat (10) @(posedge aclk);
         rdc(ACC_OFS_CTRL, 32'h88 | 32'(m) | (RISE_HIT[m] ? 32'h20 : 32'h0));
      end
      $display("test modes done");
      wr(ACC_OFS_CTRL, 32'ha3);
      rd(ACC_OFS_ISTAT);
      wr(ACC_OFS_IMASK, 32'h1);
      rdc(ACC_OFS_IMASK, 32'h1);
      cmp(irq, 1'b0);
      vpin <= 8'h32;
      repeat (10) @(posedge aclk);
      cmp(irq, 1'b1);
      rdc(ACC_OFS_ISTAT, 32'h3);
      repeat (2) @(posedge aclk);
      cmp(irq, 1'b0);
      $display("test status done");
      vbg <= 8'hc8;
      wr(ACC_OFS_CTRL, 32'he3);
      repeat (10) @(posedge aclk);
      rdc(ACC_OFS_CTRL, 32'heb);
      cmp(bgs, 1'b1);
      wr(ACC_OFS_CTRL, 32'h28);
      repeat (4) @(posedge aclk);
      rdc(ACC_OFS_CTRL, 32'h0);
      cmp(power_on, 1'b0);
      $display("test reference done");
      wr(ACC_OFS_CTRL, 32'h97);
      repeat (10) @(posedge aclk);
      deep_stop <= 1'b1;
      repeat (3) @(posedge aclk);
      cmp({power_on, pin_oe_n, irq}, 3'b010);
      deep_stop <= 1'b0;
      @(posedge aclk);
      rdc(ACC_OFS_CTRL, 32'h0);
      rdc(ACC_OFS_IMASK, 32'h0);
      $display("test deep stop done");
      give_verdict();
   end
endmodule

// file: verilog/acc_edge.sv
// edge detector on the filtered comparator level with selectable mode
`timescale 1ns/1ns
module acc_edge (
   input wire logic aclk,
   input wire logic aresetn,
   input wire logic clr,
   input wire logic enable,
   input wire logic [1:0] mode,
   input wire logic level,
   output acc_pkg::acc_event_t evt
);
   import acc_pkg::*;

   logic prev_r, prev_nxt;
   logic rise, fall;

   // ==========================================================
   // previous level follows even while off, so enabling makes no false edge
   always_comb begin
      prev_nxt = clr ? 1'b0 : level;
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         prev_r <= 1'b0;
      end else begin
         prev_r <= prev_nxt;
      end
   end

   assign rise = enable & level & ~prev_r;
   assign fall = enable & ~level & prev_r;

   always_comb begin
      evt.tgl = rise | fall;
      case (mode)
         ACC_MODE_FALL0: evt.cmp = fall;
         ACC_MODE_RISE: evt.cmp = rise;
         ACC_MODE_FALL2: evt.cmp = fall;
         ACC_MODE_BOTH: evt.cmp = rise | fall;
         default: evt.cmp = 1'b0;
      endcase
   end
endmodule

// file: verilog/acc_pkg.sv
// package for the comparator control block: offsets, fields, resets, types
package acc_pkg;
   // ==========================================================
   // register byte offsets
   localparam logic [3:0] ACC_OFS_CTRL = 4'h0;
   localparam logic [3:0] ACC_OFS_ISTAT = 4'h4;
   localparam logic [3:0] ACC_OFS_IMASK = 4'h8;

   // ==========================================================
   // status/control bit positions
   localparam int ACC_BIT_EN = 7;
   localparam int ACC_BIT_BGS = 6;
   localparam int ACC_BIT_FLAG = 5;
   localparam int ACC_BIT_IE = 4;
   localparam int ACC_BIT_OUT = 3;
   localparam int ACC_BIT_OPE = 2;
   localparam int ACC_BIT_MODE = 0;

   // ==========================================================
   // interrupt status/mask bit positions
   localparam int ACC_IBIT_CMP = 0;
   localparam int ACC_IBIT_TGL = 1;
   localparam int ACC_IRQ_W = 2;

   // ==========================================================
   // reset values, mode encodings and bus answers
   localparam logic [7:0] ACC_CTRL_RST = 8'h00;
   localparam logic [1:0] ACC_IRQ_RST = 2'h0;
   localparam logic [1:0] ACC_MODE_FALL0 = 2'h0;
   localparam logic [1:0] ACC_MODE_RISE = 2'h1;
   localparam logic [1:0] ACC_MODE_FALL2 = 2'h2;
   localparam logic [1:0] ACC_MODE_BOTH = 2'h3;
   localparam logic [1:0] ACC_RESP_OKAY = 2'h0;
   localparam logic [1:0] ACC_RESP_SLVERR = 2'h2;

   // ==========================================================
   // software-writable control fields
   typedef struct packed {
      logic en;
      logic bgs;
      logic ie;
      logic ope;
      logic [1:0] mode;
   } acc_ctrl_t;

   localparam acc_ctrl_t ACC_CTRL_T_RST = '{en: 1'b0, bgs: 1'b0, ie: 1'b0, ope: 1'b0,
                                           mode: 2'h0};

   // one detected event, split by kind
   typedef struct packed {
      logic cmp;
      logic tgl;
   } acc_event_t;
endpackage

// file: verilog/acc_sync.sv
// three-stage input synchroniser with agreement filter
`timescale 1ns/1ns
module acc_sync (
   input wire logic aclk,
   input wire logic aresetn,
   input wire logic clr,
   input wire logic async_in,
   output logic level
);
   import acc_pkg::*;

   logic s1_r, s2_r, s3_r, lvl_r;
   logic s1_nxt, s2_nxt, s3_nxt, lvl_nxt;

   // ==========================================================
   // stage one feeds only stage two
   always_comb begin
      s1_nxt = async_in;
      s2_nxt = s1_r;
      s3_nxt = s2_r;
      lvl_nxt = (s2_r == s3_r) ? s3_r : lvl_r;
      // a deep stop leaves the whole chain at its reset state, not just the level
      if (clr) begin
         s1_nxt = 1'b0;
         s2_nxt = 1'b0;
         s3_nxt = 1'b0;
         lvl_nxt = 1'b0;
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         s1_r <= 1'b0;
         s2_r <= 1'b0;
         s3_r <= 1'b0;
         lvl_r <= 1'b0;
      end else begin
         s1_r <= s1_nxt;
         s2_r <= s2_nxt;
         s3_r <= s3_nxt;
         lvl_r <= lvl_nxt;
      end
   end

   assign level = lvl_r;
endmodule

// file: verilog/acc_top.sv
// comparator control block: axi4-lite registers, event flag, pins, interrupt
//
// The AXI4-Lite interface to the registers and the placing of the registers were left to the implementer.
`timescale 1ns/1ns
module acc_top (
   input wire logic aclk,
   input wire logic aresetn,
   input wire logic [3:0] s_axi_awaddr,
   input wire logic s_axi_awvalid,
   output logic s_axi_awready,
   input wire logic [31:0] s_axi_wdata,
   input wire logic [3:0] s_axi_wstrb,
   input wire logic s_axi_wvalid,
   output logic s_axi_wready,
   output logic [1:0] s_axi_bresp,
   output logic s_axi_bvalid,
   input wire logic s_axi_bready,
   input wire logic [3:0] s_axi_araddr,
   input wire logic s_axi_arvalid,
   output logic s_axi_arready,
   output logic [31:0] s_axi_rdata,
   output logic [1:0] s_axi_rresp,
   output logic s_axi_rvalid,
   input wire logic s_axi_rready,
   input wire logic deep_stop,
   input wire logic comparator_core_out,
   output logic analog_power_on,
   output logic bandgap_select,
   output logic comparator_output_pin,
   output logic comparator_output_pin_oe_n,
   output logic irq
);
   import acc_pkg::*;

   // ==========================================================
   // declarations
   acc_ctrl_t ctrl_r, ctrl_nxt;
   logic flag_r, flag_nxt;
   logic [ACC_IRQ_W-1:0] istat_r, istat_nxt;
   logic [ACC_IRQ_W-1:0] imask_r, imask_nxt;

   logic aw_hold_r, aw_hold_nxt;
   logic [3:0] aw_addr_r, aw_addr_nxt;
   logic w_hold_r, w_hold_nxt;
   logic [31:0] w_data_r, w_data_nxt;
   logic [3:0] w_strb_r, w_strb_nxt;
   logic awready_r, awready_nxt;
   logic wready_r, wready_nxt;
   logic bvalid_r, bvalid_nxt;
   logic [1:0] bresp_r, bresp_nxt;
   logic arready_r, arready_nxt;
   logic rvalid_r, rvalid_nxt;
   logic [31:0] rdata_r, rdata_nxt;
   logic [1:0] rresp_r, rresp_nxt;

   logic power_r, power_nxt;
   logic bgs_out_r, bgs_out_nxt;
   logic pin_r, pin_nxt;
   logic pin_oe_n_r, pin_oe_n_nxt;
   logic irq_r, irq_nxt;

   logic aw_take, w_take, wr_go, rd_go;
   logic wr_ctrl, wr_imask, rd_istat;
   logic cmp_level, readback;
   logic [7:0] ctrl_view;
   acc_event_t evt;

   // ==========================================================
   // comparator output path
   // the core output is asynchronous to aclk; the filter adds three to four
   // cycles of latency but keeps chatter near the threshold out of the flag
   acc_sync u_sync (
      .aclk(aclk),
      .aresetn(aresetn),
      .clr(deep_stop),
      .async_in(comparator_core_out),
      .level(cmp_level)
   );

   acc_edge u_edge (
      .aclk(aclk),
      .aresetn(aresetn),
      .clr(deep_stop),
      .enable(ctrl_r.en & ~deep_stop),
      .mode(ctrl_r.mode),
      .level(cmp_level),
      .evt(evt)
   );

   // the core is high when the noninverting input is above; no inversion here
   assign readback = ctrl_r.en & cmp_level;

   always_comb begin
      ctrl_view = 8'h00;
      ctrl_view[ACC_BIT_EN] = ctrl_r.en;
      ctrl_view[ACC_BIT_BGS] = ctrl_r.bgs;
      ctrl_view[ACC_BIT_FLAG] = flag_r;
      ctrl_view[ACC_BIT_IE] = ctrl_r.ie;
      ctrl_view[ACC_BIT_OUT] = readback;
      ctrl_view[ACC_BIT_OPE] = ctrl_r.ope;
      ctrl_view[ACC_BIT_MODE +: 2] = ctrl_r.mode;
   end

   // ==========================================================
   // axi4-lite handshakes
   assign aw_take = s_axi_awvalid & awready_r;
   assign w_take = s_axi_wvalid & wready_r;
   assign wr_go = aw_hold_r & w_hold_r & ~bvalid_r;
   assign rd_go = s_axi_arvalid & arready_r;

   // full-address decode, so an access answered with an error has no side effect
   assign wr_ctrl = wr_go & (aw_addr_r == ACC_OFS_CTRL) & w_strb_r[0];
   assign wr_imask = wr_go & (aw_addr_r == ACC_OFS_IMASK) & w_strb_r[0];
   assign rd_istat = rd_go & (s_axi_araddr == ACC_OFS_ISTAT);

   always_comb begin
      aw_hold_nxt = aw_hold_r;
      aw_addr_nxt = aw_addr_r;
      w_hold_nxt = w_hold_r;
      w_data_nxt = w_data_r;
      w_strb_nxt = w_strb_r;
      bvalid_nxt = bvalid_r;
      bresp_nxt = bresp_r;
      if (aw_take) begin
         aw_hold_nxt = 1'b1;
         aw_addr_nxt = s_axi_awaddr;
      end
      if (w_take) begin
         w_hold_nxt = 1'b1;
         w_data_nxt = s_axi_wdata;
         w_strb_nxt = s_axi_wstrb;
      end
      if (bvalid_r & s_axi_bready) begin
         bvalid_nxt = 1'b0;
      end
      if (wr_go) begin
         aw_hold_nxt = 1'b0;
         w_hold_nxt = 1'b0;
         bvalid_nxt = 1'b1;
         case (aw_addr_r)
            ACC_OFS_CTRL: bresp_nxt = ACC_RESP_OKAY;
            ACC_OFS_ISTAT: bresp_nxt = ACC_RESP_OKAY;
            ACC_OFS_IMASK: bresp_nxt = ACC_RESP_OKAY;
            default: bresp_nxt = ACC_RESP_SLVERR;
         endcase
      end
      // one write at a time: no new address or data until the answer is taken
      awready_nxt = ~aw_hold_nxt & ~bvalid_nxt;
      wready_nxt = ~w_hold_nxt & ~bvalid_nxt;
   end

   always_comb begin
      rvalid_nxt = rvalid_r;
      rdata_nxt = rdata_r;
      rresp_nxt = rresp_r;
      if (rvalid_r & s_axi_rready) begin
         rvalid_nxt = 1'b0;
      end
      if (rd_go) begin
         rvalid_nxt = 1'b1;
         rdata_nxt = 32'h0000_0000;
         rresp_nxt = ACC_RESP_OKAY;
         case (s_axi_araddr)
            ACC_OFS_CTRL: rdata_nxt[7:0] = ctrl_view;
            ACC_OFS_ISTAT: rdata_nxt[ACC_IRQ_W-1:0] = istat_r;
            ACC_OFS_IMASK: rdata_nxt[ACC_IRQ_W-1:0] = imask_r;
            default: rresp_nxt = ACC_RESP_SLVERR;
         endcase
      end
      arready_nxt = ~rvalid_nxt;
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         aw_hold_r <= 1'b0;
         aw_addr_r <= 4'h0;
         w_hold_r <= 1'b0;
         w_data_r <= 32'h0000_0000;
         w_strb_r <= 4'h0;
         awready_r <= 1'b0;
         wready_r <= 1'b0;
         bvalid_r <= 1'b0;
         bresp_r <= ACC_RESP_OKAY;
         arready_r <= 1'b0;
         rvalid_r <= 1'b0;
         rdata_r <= 32'h0000_0000;
         rresp_r <= ACC_RESP_OKAY;
      end else begin
         aw_hold_r <= aw_hold_nxt;
         aw_addr_r <= aw_addr_nxt;
         w_hold_r <= w_hold_nxt;
         w_data_r <= w_data_nxt;
         w_strb_r <= w_strb_nxt;
         awready_r <= awready_nxt;
         wready_r <= wready_nxt;
         bvalid_r <= bvalid_nxt;
         bresp_r <= bresp_nxt;
         arready_r <= arready_nxt;
         rvalid_r <= rvalid_nxt;
         rdata_r <= rdata_nxt;
         rresp_r <= rresp_nxt;
      end
   end

   // ==========================================================
   // control register, event flag, interrupt status and mask
   // wait, stop3 and debug halt have no input here: the block simply keeps
   // running on aclk in those modes, and its interrupt serves as wake-up
   always_comb begin
      ctrl_nxt = ctrl_r;
      flag_nxt = flag_r;
      imask_nxt = imask_r;
      istat_nxt = istat_r;
      if (wr_ctrl) begin
         ctrl_nxt.en = w_data_r[ACC_BIT_EN];
         ctrl_nxt.bgs = w_data_r[ACC_BIT_BGS];
         ctrl_nxt.ie = w_data_r[ACC_BIT_IE];
         ctrl_nxt.ope = w_data_r[ACC_BIT_OPE];
         ctrl_nxt.mode = w_data_r[ACC_BIT_MODE +: 2];
         if (w_data_r[ACC_BIT_FLAG]) begin
            flag_nxt = 1'b0;
         end
      end
      if (evt.cmp) begin
         flag_nxt = 1'b1;
      end
      if (wr_imask) begin
         imask_nxt = w_data_r[ACC_IRQ_W-1:0];
      end
      if (rd_istat) begin
         istat_nxt = {ACC_IRQ_W{1'b0}};
      end
      // an event in the clearing cycle survives the clear
      istat_nxt[ACC_IBIT_CMP] = istat_nxt[ACC_IBIT_CMP] | evt.cmp;
      istat_nxt[ACC_IBIT_TGL] = istat_nxt[ACC_IBIT_TGL] | evt.tgl;
      if (deep_stop) begin
         ctrl_nxt = ACC_CTRL_T_RST;
         flag_nxt = ACC_CTRL_RST[ACC_BIT_FLAG];
         imask_nxt = ACC_IRQ_RST;
         istat_nxt = ACC_IRQ_RST;
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         ctrl_r <= ACC_CTRL_T_RST;
         flag_r <= 1'b0;
         imask_r <= ACC_IRQ_RST;
         istat_r <= ACC_IRQ_RST;
      end else begin
         ctrl_r <= ctrl_nxt;
         flag_r <= flag_nxt;
         imask_r <= imask_nxt;
         istat_r <= istat_nxt;
      end
   end

   // ==========================================================
   // analog controls, output pin, interrupt line
   always_comb begin
      power_nxt = ctrl_nxt.en & ~deep_stop;
      bgs_out_nxt = ctrl_nxt.bgs;
      // next values keep the pin drive in step with the core power switch
      pin_nxt = ctrl_nxt.ope & readback;
      pin_oe_n_nxt = ~(ctrl_nxt.ope & ctrl_nxt.en);
      irq_nxt = (ctrl_nxt.ie & flag_nxt) | (|(istat_nxt & imask_nxt));
      if (deep_stop) begin
         pin_nxt = 1'b0;
         pin_oe_n_nxt = 1'b1;
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         power_r <= 1'b0;
         bgs_out_r <= 1'b0;
         pin_r <= 1'b0;
         pin_oe_n_r <= 1'b1;
         irq_r <= 1'b0;
      end else begin
         power_r <= power_nxt;
         bgs_out_r <= bgs_out_nxt;
         pin_r <= pin_nxt;
         pin_oe_n_r <= pin_oe_n_nxt;
         irq_r <= irq_nxt;
      end
   end

   // ==========================================================
   // port drivers
   assign s_axi_awready = awready_r;
   assign s_axi_wready = wready_r;
   assign s_axi_bvalid = bvalid_r;
   assign s_axi_bresp = bresp_r;
   assign s_axi_arready = arready_r;
   assign s_axi_rvalid = rvalid_r;
   assign s_axi_rdata = rdata_r;
   assign s_axi_rresp = rresp_r;
   assign analog_power_on = power_r;
   assign bandgap_select = bgs_out_r;
   assign comparator_output_pin = pin_r;
   assign comparator_output_pin_oe_n = pin_oe_n_r;
   assign irq = irq_r;
endmodule
